/* poc_pkg.sv */
// poc_pkg: constants and types for the pll output control configuration block
// assumes a 32-bit serial configuration word with its 4-bit address in the low bits
package poc_pkg;
   localparam int unsigned NUM_OUTPUTS   = 8;
   localparam int unsigned WORD_W        = 32;
   localparam int unsigned R_W           = 12;
   localparam int unsigned N_W           = 18;
   // register addresses carried in word bits 3:0
   localparam logic [3:0]  ADDR_OUT_LAST = 4'h7;
   localparam logic [3:0]  ADDR_LOCK_CFG = 4'hb;
   localparam logic [3:0]  ADDR_PLL_REF  = 4'he;
   localparam logic [3:0]  ADDR_PLL_FB   = 4'hf;
   // field positions
   localparam int unsigned POS_RESET     = 31;
   localparam int unsigned POS_OUT_EN    = 16;
   localparam int unsigned POS_PRESCALE  = 15;
   localparam int unsigned POS_ALL_EN    = 27;
   localparam int unsigned POS_PDOWN     = 26;
   localparam int unsigned POS_TRI       = 25;
   localparam int unsigned POS_POL       = 24;
   localparam int unsigned POS_LSEL      = 20;
   localparam int unsigned POS_R         = 8;
   localparam int unsigned POS_GAIN      = 30;
   localparam int unsigned POS_N         = 8;
   // reset values
   localparam logic [R_W-1:0] RST_R_DIV  = 12'h00a;
   localparam logic [N_W-1:0] RST_N_DIV  = 18'h002f8;
   localparam logic           RST_ALL_EN = 1'b1;
   // lock pin select codes
   localparam logic [3:0]  LSEL_HIZ      = 4'h0;
   localparam logic [3:0]  LSEL_HIGH     = 4'h1;
   localparam logic [3:0]  LSEL_LOW      = 4'h2;
   localparam logic [3:0]  LSEL_DLD_HI   = 4'h3;
   localparam logic [3:0]  LSEL_DLD_LO   = 4'h4;
   localparam logic [3:0]  LSEL_ALD_PP   = 4'h5;
   localparam logic [3:0]  LSEL_ALD_NMOS = 4'h6;
   localparam logic [3:0]  LSEL_ALD_PMOS = 4'h7;
   localparam logic [3:0]  LSEL_N_HALF   = 4'h9;
   localparam logic [3:0]  LSEL_R_HALF   = 4'hb;
   // digital lock detect
   localparam logic [1:0]  PRESCALE_LAST = 2'h3;
   localparam logic [2:0]  EXPECT_LOCK_DETECT_PRESCALE   = 3'h4;
   localparam logic [2:0]  EXPECT_DIV1   = 3'h1;
   localparam int unsigned LOCK_COUNT    = 8;

   typedef struct packed {
      logic [NUM_OUTPUTS-1:0] out_en;
      logic                   all_out_en;
      logic                   power_down;
      logic                   pump_tri;
      logic                   pump_pol;
      logic [3:0]             lock_sel;
      logic [R_W-1:0]         r_div;
      logic                   prescale;
      logic [1:0]             pump_gain;
      logic [N_W-1:0]         n_div;
   } poc_cfg_t;

   localparam poc_cfg_t CFG_RESET = '{
      out_en: '0, all_out_en: RST_ALL_EN, power_down: 1'b0, pump_tri: 1'b0,
      pump_pol: 1'b0, lock_sel: LSEL_HIZ, r_div: RST_R_DIV, prescale: 1'b0,
      pump_gain: 2'h0, n_div: RST_N_DIV};

   typedef struct packed {
      logic       tristate;
      logic       polarity;
      logic [1:0] gain;
   } poc_pump_t;
endpackage : poc_pkg

/* poc_config.sv */
// poc_config: serial configuration, output gating, R/N dividers, lock pin mux
// assumes serial pins, strobes and lock inputs are synchronous to ref_clk
// Functional notes
// - output drives only with its enable bit set and both global gates open
// - global enable pin low turns every clock output off
// - global output enable bit zero turns all outputs off; resets to one
// - prescale bit set divides lock detect input frequency by four
// - reference divider is 12-bit binary 1 to 4095, reset 10, zero invalid
// - lock pin select codes 0 to 7 give hiz, high, low, digital, analog lock
// - code 9 gives feedback divider/2, code 11 reference divider/2
// - power down bit turns off every block regardless of anything else
// - pump tristate bit places charge pump output in high impedance
// - pump polarity bit zero negative, one positive
// - feedback divider is 18-bit binary 1 to 262143, reset 760, zero illegal
// - feedback divider counts oscillator divider output, before phase detector
// - pump gain codes 0 to 3 select 1x, 4x, 16x, 32x
// - global output enable bit sits at bit 27 of second pll register
`timescale 1ns/1ps
`default_nettype none
module poc_config
   import poc_pkg::*;
#(
   parameter int unsigned LOCK_GOOD = LOCK_COUNT
) (
   input  wire logic                      ref_clk,
   input  wire logic                      sys_rst,
   input  wire logic                      ser_clk,
   input  wire logic                      ser_data,
   input  wire logic                      ser_latch,
   input  wire logic                      global_enable_pin,
   input  wire logic                      osc_div_pulse,
   input  wire logic                      analog_lock,
   output logic [poc_pkg::NUM_OUTPUTS-1:0] clock_output_n_en,
   output logic                           power_down,
   output poc_pkg::poc_pump_t             pump,
   output logic                           lock_status_pin_out,
   output logic                           lock_status_pin_oe,
   output logic                           digital_locked
);
   import poc_pkg::*;

   logic [WORD_W-1:0] shift;
   logic              ser_clk_d;
   logic              ser_latch_d;
   poc_cfg_t          cfg;
   poc_cfg_t          next_cfg;
   logic [R_W-1:0]    r_count;
   logic [N_W-1:0]    n_count;
   logic              r_half;
   logic              n_half;
   logic [1:0]        pre_cnt;
   logic [2:0]        n_seen;
   logic [3:0]        lock_cnt;

   wire       shift_edge = ser_clk & ~ser_clk_d;
   wire       apply      = ser_latch & ~ser_latch_d;
   wire [3:0] addr       = shift[3:0];
   wire       run        = ~cfg.power_down;
   wire       r_tc       = run && (cfg.r_div != '0) && (r_count <= 12'h001);
   wire       n_tc       = run && (cfg.n_div != '0) && osc_div_pulse && (n_count <= 18'h00001);
   wire       lock_strobe = r_tc && (!cfg.prescale || pre_cnt == PRESCALE_LAST);
   wire [2:0] expect_n   = cfg.prescale ? EXPECT_LOCK_DETECT_PRESCALE : EXPECT_DIV1;
   wire [2:0] n_total    = n_seen + {2'h0, n_tc};
   wire       good_cycle = (n_total == expect_n);
   wire [NUM_OUTPUTS-1:0] next_en = (global_enable_pin && cfg.all_out_en && run)
                                    ? cfg.out_en : '0;

   // serial shift; only the latch edge moves the word into the live settings
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         shift       <= '0;
         ser_clk_d   <= 1'b0;
         ser_latch_d <= 1'b0;
      end else begin
         ser_clk_d   <= ser_clk;
         ser_latch_d <= ser_latch;
         if (shift_edge) begin
            shift <= {shift[WORD_W-2:0], ser_data};
         end
      end
   end

   always_comb begin
      next_cfg = cfg;
      if (apply) begin
         if (addr <= ADDR_OUT_LAST) begin
            next_cfg.out_en[addr[2:0]] = shift[POS_OUT_EN];
            if (addr == 4'h0 && shift[POS_RESET]) begin
               next_cfg = CFG_RESET;
            end
         end
         if (addr == ADDR_LOCK_CFG) begin
            next_cfg.prescale = shift[POS_PRESCALE];
         end
         if (addr == ADDR_PLL_REF) begin
            next_cfg.all_out_en = shift[POS_ALL_EN];
            next_cfg.power_down = shift[POS_PDOWN];
            next_cfg.pump_tri   = shift[POS_TRI];
            next_cfg.pump_pol   = shift[POS_POL];
            next_cfg.lock_sel   = shift[POS_LSEL +: 4];
            next_cfg.r_div      = shift[POS_R +: R_W];
         end
         if (addr == ADDR_PLL_FB) begin
            next_cfg.pump_gain = shift[POS_GAIN +: 2];
            next_cfg.n_div     = shift[POS_N +: N_W];
         end
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfg <= CFG_RESET;
      end else begin
         cfg <= next_cfg;
      end
   end

   // output gating and pump controls, registered
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         clock_output_n_en <= '0;
         power_down        <= 1'b0;
         pump              <= '0;
      end else begin
         clock_output_n_en <= next_en;
         power_down        <= cfg.power_down;
         pump.tristate     <= cfg.pump_tri || cfg.power_down;
         pump.polarity     <= cfg.pump_pol;
         pump.gain         <= cfg.pump_gain;
      end
   end

   // dividers; a zero divide value never reaches terminal, so no edges come out
   // a new divide value is picked up at the next terminal, or at once out of power down
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         r_count <= RST_R_DIV;
         n_count <= RST_N_DIV;
         r_half  <= 1'b0;
         n_half  <= 1'b0;
      end else if (!run) begin
         r_count <= cfg.r_div;
         n_count <= cfg.n_div;
      end else begin
         r_count <= r_tc ? cfg.r_div : r_count - 12'h001;
         if (n_tc) begin
            n_count <= cfg.n_div;
         end else if (osc_div_pulse) begin
            n_count <= n_count - 18'h00001;
         end
         r_half <= r_half ^ r_tc;
         n_half <= n_half ^ n_tc;
      end
   end

   // digital lock: one feedback edge per reference edge (four per prescaled strobe), many in a row
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pre_cnt  <= '0;
         n_seen   <= '0;
         lock_cnt <= '0;
      end else if (!run) begin
         pre_cnt  <= '0;
         n_seen   <= '0;
         lock_cnt <= '0;
      end else begin
         if (r_tc) begin
            pre_cnt <= cfg.prescale ? pre_cnt + 2'h1 : 2'h0;
         end
         if (lock_strobe) begin
            n_seen <= '0;
            if (!good_cycle) begin
               lock_cnt <= '0;
            end else if (lock_cnt != 4'(LOCK_GOOD)) begin
               lock_cnt <= lock_cnt + 4'h1;
            end
         end else if (n_tc && n_seen != 3'h7) begin
            n_seen <= n_seen + 3'h1;
         end
      end
   end

   assign digital_locked = (lock_cnt == 4'(LOCK_GOOD));

   // lock pin mux; invalid codes leave the pin undriven
   always_comb begin
      lock_status_pin_out = 1'b0;
      lock_status_pin_oe  = run;
      unique case (cfg.lock_sel)
         LSEL_HIGH:     lock_status_pin_out = 1'b1;
         LSEL_LOW:      lock_status_pin_out = 1'b0;
         LSEL_DLD_HI:   lock_status_pin_out = digital_locked;
         LSEL_DLD_LO:   lock_status_pin_out = ~digital_locked;
         LSEL_ALD_PP:   lock_status_pin_out = analog_lock;
         LSEL_ALD_NMOS: lock_status_pin_oe  = run && !analog_lock;
         LSEL_ALD_PMOS: begin
            lock_status_pin_out = 1'b1;
            lock_status_pin_oe  = run && analog_lock;
         end
         LSEL_N_HALF:   lock_status_pin_out = n_half;
         LSEL_R_HALF:   lock_status_pin_out = r_half;
         default:       lock_status_pin_oe  = 1'b0;
      endcase
   end

   a_out_gate_bits: assert property (@(posedge ref_clk) disable iff (sys_rst)
      ##1 (clock_output_n_en & ~$past(cfg.out_en)) == '0)
      else $error("output enabled without its enable bit");
   a_pin_low_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !global_enable_pin |=> clock_output_n_en == '0)
      else $error("output on while global pin low");
   a_global_bit_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !cfg.all_out_en |=> clock_output_n_en == '0)
      else $error("output on while global bit clear");
   a_pdown_all_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
      cfg.power_down |=> (clock_output_n_en == '0) && pump.tristate && power_down)
      else $error("block active in power down");
   a_pump_tristate: assert property (@(posedge ref_clk) disable iff (sys_rst)
      cfg.pump_tri |=> pump.tristate)
      else $error("pump not tristated");
   a_prescale_strobe: assert property (@(posedge ref_clk) disable iff (sys_rst)
      cfg.prescale && lock_strobe |-> r_tc && pre_cnt == PRESCALE_LAST)
      else $error("prescaled lock strobe off its fourth edge");
   a_r_reload_val: assert property (@(posedge ref_clk) disable iff (sys_rst)
      r_tc |=> r_count == $past(cfg.r_div))
      else $error("reference divider reload wrong");
   a_n_half_toggle: assert property (@(posedge ref_clk) disable iff (sys_rst)
      n_tc |=> n_half != $past(n_half))
      else $error("feedback half rate did not toggle");
   a_lock_pin_hiz: assert property (@(posedge ref_clk) disable iff (sys_rst)
      cfg.lock_sel == LSEL_HIZ |-> !lock_status_pin_oe)
      else $error("lock pin driven in hiz code");
   a_cfg_on_latch: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !$stable(cfg) |-> $past(apply))
      else $error("settings changed without a latch");
   c_output_on: cover property (@(posedge ref_clk) disable iff (sys_rst)
      clock_output_n_en != '0);
   c_locked: cover property (@(posedge ref_clk) disable iff (sys_rst) digital_locked);
   c_soft_reset: cover property (@(posedge ref_clk) disable iff (sys_rst)
      apply && addr == 4'h0 && shift[POS_RESET]);
endmodule : poc_config
`default_nettype wire

/* poc_host.sv */
// poc_host: host model shifting 32-bit configuration words into the serial port
// assumes the bench calls send() from its main sequence, one word at a time
`timescale 1ns/1ps
`default_nettype none
module poc_host (
   input  wire logic ref_clk,
   output logic      ser_clk,
   output logic      ser_data,
   output logic      ser_latch
);
   initial begin
      ser_clk = 1'b0;
      ser_data = 1'b0;
      ser_latch = 1'b0;
   end
   // msb first, each level held a full cycle; latch stays low while shifting
   task automatic send(input logic [31:0] w);
      for (int i = 31; i >= 0; i--) begin
         @(posedge ref_clk);
         #1;
         ser_data = w[i];
         ser_clk = 1'b1;
         @(posedge ref_clk);
         #1;
         ser_clk = 1'b0;
      end
      @(posedge ref_clk);
      #1;
      ser_latch = 1'b1;
      @(posedge ref_clk);
      #1;
      ser_latch = 1'b0;
      // data is released after the word: show the inverse, never a stale bit
      ser_data = ~ser_data;
   endtask : send
endmodule : poc_host
`default_nettype wire

/* pll_output_control_config_tb_top.sv */
// testbench for poc_config: serial writes, output gating, pump fields, lock pin
// assumes poc_host drives the serial pins and a 100 MHz ref_clk
`timescale 1ns/1ps
`default_nettype none
module pll_output_control_config_tb_top;
   import poc_pkg::*;
   logic                   ref_clk, sys_rst, ser_clk, ser_data, ser_latch;
   logic                   global_enable_pin, osc_div_pulse, analog_lock;
   logic [NUM_OUTPUTS-1:0] clk_en;
   logic                   power_down, lock_out, lock_oe, dlocked, v;
   poc_pump_t              pump;
   int                     err_count, comparisons, cycles;
   logic [1:0]             lk;

   poc_host host (.ref_clk(ref_clk), .ser_clk(ser_clk), .ser_data(ser_data),
                  .ser_latch(ser_latch));
   poc_config #(.LOCK_GOOD(2)) DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .ser_clk(ser_clk),
      .ser_data(ser_data), .ser_latch(ser_latch), .global_enable_pin(global_enable_pin),
      .osc_div_pulse(osc_div_pulse), .analog_lock(analog_lock), .clock_output_n_en(clk_en),
      .power_down(power_down), .pump(pump), .lock_status_pin_out(lock_out),
      .lock_status_pin_oe(lock_oe), .digital_locked(dlocked));

   initial ref_clk = 1'b0;
   always #5 ref_clk = ~ref_clk;
   // one-cycle pulse every other cycle
   always @(posedge ref_clk) osc_div_pulse <= #1 ~osc_div_pulse;
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 8000) begin
         err_count++;
         test_done();
      end
   end

   task automatic test_done();
      $display("comparisons=%0d err_count=%0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : test_done
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [31:0] w);
      host.send(w);
      repeat (3) @(posedge ref_clk);
      #1;
   endtask : wr
   function automatic logic [31:0] w_out(input logic [3:0] a, input logic en);
      return {15'h0, en, 12'h0, a};
   endfunction : w_out
   // second pll register always written whole, reserved bits zero
   function automatic logic [31:0] w_pll(input logic all, pd, tri_b, pol,
                                         input logic [3:0] sel, input logic [11:0] r);
      return {4'h0, all, pd, tri_b, pol, sel, r, 4'h0, ADDR_PLL_REF};
   endfunction : w_pll
   function automatic logic [31:0] w_fb(input logic [1:0] g, input logic [17:0] n);
      return {g, 4'h0, n, 4'h0, ADDR_PLL_FB};
   endfunction : w_fb

   initial begin
      sys_rst = 1'b1;
      global_enable_pin = 1'b1;
      osc_div_pulse = 1'b0;
      analog_lock = 1'b1;
      repeat (2) @(posedge ref_clk);
      #1;
      sys_rst = 1'b0;
      // prescale left at reset: lock detect runs below the fast range here
      chk(clk_en, 8'h00);
      chk({4'h0, pump}, 8'h00);
      chk({7'h0, power_down}, 8'h00);
      chk({7'h0, lock_oe}, 8'h00);
      for (int i = 0; i < 8; i++) begin
         wr(w_out(4'(i), 1'b1));
         chk(clk_en, 8'((16'h2 << i) - 1));
      end
      global_enable_pin = 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      chk(clk_en, 8'h00);
      global_enable_pin = 1'b1;
      repeat (2) @(posedge ref_clk);
      #1;
      chk(clk_en, 8'hff);
      wr(w_pll(1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 12'h00a));
      chk(clk_en, 8'h00);
      wr(w_pll(1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 12'h00a));
      chk(clk_en, 8'hff);
      for (int g = 0; g < 4; g++) begin
         wr(w_fb(2'(g), 18'h002f8));
         wr(w_pll(1'b1, 1'b0, g[0], g[1], 4'h0, 12'h00a));
         chk({4'h0, pump}, {4'h0, g[0], g[1], 2'(g)});
      end
      // open drain codes with analog lock asserted: nmos releases, pmos drives high
      for (int c = 0; c < 9; c++) begin
         wr(w_pll(1'b1, 1'b0, 1'b0, 1'b0, 4'(c), 12'h00a));
         // r=10 against n=760: far from lock, so the digital codes read unlocked
         case (c)
            1, 4, 5, 7: lk = 2'h3;
            2, 3: lk = 2'h2;
            default: lk = 2'h0;
         endcase
         chk({6'h0, lock_oe, lock_oe & lock_out}, {6'h0, lk});
         if (c >= 5 && c <= 7) begin
            analog_lock = 1'b0;
            @(posedge ref_clk);
            #1;
            chk({6'h0, lock_oe, lock_oe & lock_out}, {6'h0, c != 7, 1'b0});
            analog_lock = 1'b1;
         end
      end
      wr(w_fb(2'h0, 18'h00001));
      // power down reloads both counters, so the new r and n apply at once
      wr(w_pll(1'b1, 1'b1, 1'b0, 1'b0, 4'h0, 12'h002));
      for (int c = 9; c < 12; c += 2) begin
         wr(w_pll(1'b1, 1'b0, 1'b0, 1'b0, 4'(c), 12'h002));
         v = lock_out;
         repeat (2) @(posedge ref_clk);
         #1;
         chk({6'h0, lock_oe, lock_out}, {6'h0, 1'b1, ~v});
      end
      // r=2 gives a 50 MHz compare rate, so the host turns the prescale on
      wr(32'h0000_800b);
      wr(w_pll(1'b1, 1'b0, 1'b0, 1'b0, 4'h3, 12'h002));
      repeat (40) @(posedge ref_clk);
      #1;
      chk({6'h0, lock_oe, lock_out}, 8'h03);
      chk({7'h0, dlocked}, 8'h01);
      // two feedback edges per four reference edges: must fall out of lock
      wr(w_fb(2'h0, 18'h00002));
      repeat (40) @(posedge ref_clk);
      #1;
      chk({7'h0, dlocked}, 8'h00);
      chk({6'h0, lock_oe, lock_out}, 8'h02);
      wr(w_pll(1'b1, 1'b1, 1'b0, 1'b0, 4'h1, 12'h00a));
      chk({6'h0, power_down, pump.tristate}, 8'h03);
      chk(clk_en, 8'h00);
      chk({7'h0, lock_oe}, 8'h00);
      wr(32'h8001_0000);
      chk({7'h0, power_down}, 8'h00);
      chk(clk_en, 8'h00);
      chk({4'h0, pump}, 8'h00);
      chk({7'h0, lock_oe}, 8'h00);
      test_done();
   end
endmodule : pll_output_control_config_tb_top
`default_nettype wire
